// file: logic/cmb_pkg.sv
// Package with the register map, carriers and helpers of the mailbox block.
`default_nettype none
package cmb_pkg;

   // =========================================================
   // Sizes
   localparam int unsigned CMB_PORTS   = 4;
   localparam int unsigned CMB_IDX_W   = 4;
   localparam int unsigned CMB_DATA_W  = 32;
   localparam int unsigned CMB_HOLD_W  = 3;

   // =========================================================
   // Register word indices
   localparam logic [3:0] CMB_IDX_MBOX_VALUE = 4'h0;
   localparam logic [3:0] CMB_IDX_MBOX_SET   = 4'h1;
   localparam logic [3:0] CMB_IDX_MBOX_CLEAR = 4'h2;
   localparam logic [3:0] CMB_IDX_IRQ_CONFIG = 4'h3;
   localparam logic [3:0] CMB_IDX_LOCK_ZERO  = 4'h4;
   localparam logic [3:0] CMB_IDX_LOCK_ONE   = 4'h5;
   localparam logic [3:0] CMB_IDX_HOLD_ZERO  = 4'h6;
   localparam logic [3:0] CMB_IDX_HOLD_ONE   = 4'h7;
   localparam logic [3:0] CMB_IDX_IRQ_FORCE  = 4'h8;
   localparam logic [3:0] CMB_IDX_IRQ_ROUTE  = 4'h9;

   // =========================================================
   // Field positions and reset values
   localparam int unsigned CMB_TAKE_BIT     = 0;
   localparam logic [31:0] CMB_MBOX_RST     = 32'h0000_0000;
   localparam logic [1:0]  CMB_POL_RST      = 2'h0;
   localparam logic [1:0]  CMB_FORCE_RST    = 2'h0;
   localparam logic [1:0]  CMB_ROUTE_RST    = 2'h0;
   localparam logic [2:0]  CMB_HOLD_FREE    = 3'h0;

   // =========================================================
   // Carriers
   typedef struct packed {
      logic                  valid;
      logic                  wr;
      logic [CMB_IDX_W-1:0]  idx;
      logic [CMB_DATA_W-1:0] wdata;
   } cmb_req_t;

   typedef struct packed {
      logic                  ack;
      logic [CMB_DATA_W-1:0] rdata;
   } cmb_rsp_t;

   // =========================================================
   // Helpers
   // Keeps only the lowest set bit: port 0 has the highest priority.
   function automatic logic [3:0] cmb_first_one(input logic [3:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 3; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'h0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction

   // Holder code of a one-hot grant: port index plus one, zero if none.
   function automatic logic [2:0] cmb_code(input logic [3:0] g);
      logic [2:0] c;
      c = CMB_HOLD_FREE;
      for (int i = 0; i < 4; i++) begin
         if (g[i]) begin
            c = 3'(i + 1);
         end
      end
      return c;
   endfunction

endpackage
`default_nettype wire

// file: logic/cmb_lock_unit.sv
// One hardware lock: take by read, release by write, holder tracking.
`timescale 1ns/100ps
`default_nettype none
module cmb_lock_unit import cmb_pkg::*; (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // Requests from the host ports
   input  wire logic [3:0] take_rd,
   input  wire logic       release_wr,
   // Results
   output logic [3:0]      grant,
   output logic [2:0]      holder_r
);

   // =========================================================
   // Grant logic
   logic       is_free;
   logic [2:0] holder_nxt;

   // A free lock goes to exactly one reader; everyone else sees zero.
   assign is_free = (holder_r == CMB_HOLD_FREE);
   assign grant   = is_free ? cmb_first_one(take_rd) : 4'h0;

   // A grant outranks a release only while free, so a taken lock
   // released in the same cycle as a read ends up free.
   assign holder_nxt = (|grant) ? cmb_code(grant) :
                       release_wr ? CMB_HOLD_FREE :
                       holder_r;

   // Holder register.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         holder_r <= CMB_HOLD_FREE;
      end else begin
         holder_r <= holder_nxt;
      end
   end

   // =========================================================
   // Checks
   // A read while free is a grab; the holder must then name the winner.
   sequence grab_s;
      is_free && (take_rd != 4'h0);
   endsequence

   grant_onehot_a: assert property (
      @(posedge clock) disable iff (sys_rst) $onehot0(grant))
      else $error("more than one lock grant");
   grab_holder_a: assert property (
      @(posedge clock) disable iff (sys_rst)
      grab_s |=> holder_r == cmb_code(cmb_first_one($past(take_rd))))
      else $error("holder not set by grant");
   // Only a release frees a taken lock; reads never move it.
   taken_hold_a: assert property (
      @(posedge clock) disable iff (sys_rst)
      !is_free && !release_wr |=> holder_r == $past(holder_r))
      else $error("taken lock changed holder");

endmodule // cmb_lock_unit
`default_nettype wire

// file: logic/cmb_mailbox.sv
// Mailbox word, two hardware locks and software interrupt lines.
`timescale 1ns/100ps
`default_nettype none
module cmb_mailbox import cmb_pkg::*; (
   // Clock and reset
   input  wire logic     clock,
   input  wire logic     sys_rst,
   // Host ports: 0 internal CPU and PCIe, 1 parallel, 2 serial, 3 mgmt.
   input  wire cmb_req_t host_req [CMB_PORTS],
   output cmb_rsp_t      host_rsp [CMB_PORTS],
   // Software interrupt lines
   output logic [1:0]    soft_irq_to_cpu_r,
   output logic [1:0]    soft_irq_to_ext_r
);

   // =========================================================
   // Address decode
   logic [3:0] wr_on [16];
   logic [3:0] rd_on [16];

   // Per register, one bit per port that hits it this cycle.
   always_comb begin
      for (int r = 0; r < 16; r++) begin
         for (int p = 0; p < 4; p++) begin
            wr_on[r][p] = host_req[p].valid && host_req[p].wr &&
                          (host_req[p].idx == 4'(r));
            rd_on[r][p] = host_req[p].valid && !host_req[p].wr &&
                          (host_req[p].idx == 4'(r));
         end
      end
   end

   // =========================================================
   // Lock instances
   logic [3:0] take_rd0;
   logic [3:0] take_rd1;
   logic       rel0;
   logic       rel1;
   logic [3:0] grant0;
   logic [3:0] grant1;
   logic [2:0] holder0;
   logic [2:0] holder1;

   // The internal CPU and PCIe share port 0, hence one holder code.
   assign take_rd0 = rd_on[CMB_IDX_LOCK_ZERO];
   assign take_rd1 = rd_on[CMB_IDX_LOCK_ONE];

   // Release asks for a one in the take bit from any port.
   always_comb begin
      rel0 = 1'b0;
      rel1 = 1'b0;
      for (int p = 0; p < 4; p++) begin
         rel0 = rel0 | (wr_on[CMB_IDX_LOCK_ZERO][p] &&
                        host_req[p].wdata[CMB_TAKE_BIT]);
         rel1 = rel1 | (wr_on[CMB_IDX_LOCK_ONE][p] &&
                        host_req[p].wdata[CMB_TAKE_BIT]);
      end
   end

   cmb_lock_unit u_lock_zero (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .take_rd    (take_rd0),
      .release_wr (rel0),
      .grant      (grant0),
      .holder_r   (holder0)
   );

   cmb_lock_unit u_lock_one (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .take_rd    (take_rd1),
      .release_wr (rel1),
      .grant      (grant1),
      .holder_r   (holder1)
   );

   // =========================================================
   // Mailbox and configuration next values
   logic [31:0] mbox_r;
   logic [31:0] mbox_nxt;
   logic [1:0]  pol_r;
   logic [1:0]  pol_nxt;
   logic [1:0]  force_r;
   logic [1:0]  force_nxt;
   logic [1:0]  route_r;
   logic [1:0]  route_nxt;

   // Writes are applied from port 3 down to port 0, so that with
   // several writers in one cycle port 0 acts last and its effect holds.
   // Each set or clear is one read-modify-write in a single cycle.
   always_comb begin
      mbox_nxt  = mbox_r;
      pol_nxt   = pol_r;
      force_nxt = force_r;
      route_nxt = route_r;
      for (int p = 3; p >= 0; p--) begin
         if (wr_on[CMB_IDX_MBOX_VALUE][p]) begin
            mbox_nxt = host_req[p].wdata;
         end
         if (wr_on[CMB_IDX_MBOX_SET][p]) begin
            mbox_nxt = mbox_nxt | host_req[p].wdata;
         end
         if (wr_on[CMB_IDX_MBOX_CLEAR][p]) begin
            mbox_nxt = mbox_nxt & ~host_req[p].wdata;
         end
         if (wr_on[CMB_IDX_IRQ_CONFIG][p]) begin
            pol_nxt = host_req[p].wdata[1:0];
         end
         if (wr_on[CMB_IDX_IRQ_FORCE][p]) begin
            force_nxt = host_req[p].wdata[1:0];
         end
         if (wr_on[CMB_IDX_IRQ_ROUTE][p]) begin
            route_nxt = host_req[p].wdata[1:0];
         end
      end
   end

   // Storage for mailbox and configuration.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mbox_r  <= CMB_MBOX_RST;
         pol_r   <= CMB_POL_RST;
         force_r <= CMB_FORCE_RST;
         route_r <= CMB_ROUTE_RST;
      end else begin
         mbox_r  <= mbox_nxt;
         pol_r   <= pol_nxt;
         force_r <= force_nxt;
         route_r <= route_nxt;
      end
   end

   // =========================================================
   // Read data
   logic [31:0] rd_val [CMB_PORTS];

   // Take reads return the grant bit; write-only ports read as zero.
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         case (host_req[p].idx)
            CMB_IDX_MBOX_VALUE: rd_val[p] = mbox_r;
            CMB_IDX_IRQ_CONFIG: rd_val[p] = {30'h0, pol_r};
            CMB_IDX_LOCK_ZERO:  rd_val[p] = {31'h0, grant0[p]};
            CMB_IDX_LOCK_ONE:   rd_val[p] = {31'h0, grant1[p]};
            CMB_IDX_HOLD_ZERO:  rd_val[p] = {29'h0, holder0};
            CMB_IDX_HOLD_ONE:   rd_val[p] = {29'h0, holder1};
            CMB_IDX_IRQ_FORCE:  rd_val[p] = {30'h0, force_r};
            CMB_IDX_IRQ_ROUTE:  rd_val[p] = {30'h0, route_r};
            default:            rd_val[p] = 32'h0000_0000;
         endcase
      end
   end

   // Every request is answered one cycle later; write answers carry zero.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         for (int p = 0; p < 4; p++) begin
            host_rsp[p] <= '0;
         end
      end else begin
         for (int p = 0; p < 4; p++) begin
            host_rsp[p].ack   <= host_req[p].valid;
            host_rsp[p].rdata <= (host_req[p].valid && !host_req[p].wr) ?
                                 rd_val[p] : 32'h0000_0000;
         end
      end
   end

   // =========================================================
   // Software interrupt lines
   logic [1:0] lock_taken;
   logic [1:0] soft_line;

   // Polarity one asserts on taken, zero asserts on free.
   assign lock_taken = {holder1 != CMB_HOLD_FREE,
                        holder0 != CMB_HOLD_FREE};
   assign soft_line  = ~(lock_taken ^ pol_r) | force_r;

   // Registered outputs keep glitches from the decode off the lines.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         soft_irq_to_cpu_r <= 2'h0;
         soft_irq_to_ext_r <= 2'h0;
      end else begin
         soft_irq_to_cpu_r <= soft_line & ~route_r;
         soft_irq_to_ext_r <= soft_line & route_r;
      end
   end

   // =========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   logic [3:0] mtouch;
   assign mtouch = wr_on[CMB_IDX_MBOX_VALUE] | wr_on[CMB_IDX_MBOX_SET] |
                   wr_on[CMB_IDX_MBOX_CLEAR];

   // Lone mailbox writers, so the expected word needs no port order.
   mbox_write_a: assert property (
      (mtouch == 4'h4) && wr_on[CMB_IDX_MBOX_VALUE][2] |=>
      mbox_r == $past(host_req[2].wdata))
      else $error("mailbox direct write lost");
   mbox_clear_a: assert property (
      (mtouch == 4'h2) && wr_on[CMB_IDX_MBOX_CLEAR][1] |=>
      mbox_r == ($past(mbox_r) & ~$past(host_req[1].wdata)))
      else $error("mailbox clear mask wrong");
   mbox_set_a: assert property (
      (mtouch == 4'h1) && wr_on[CMB_IDX_MBOX_SET][0] |=>
      mbox_r == ($past(mbox_r) | $past(host_req[0].wdata)))
      else $error("mailbox set mask wrong");

   // Take from a single port, refusal seen at port 1, and release with no reader.
   take_free_a: assert property (
      (holder0 == CMB_HOLD_FREE) && (take_rd0 == 4'h8) |=>
      (host_rsp[3].rdata == 32'h1) && (holder0 == 3'h4))
      else $error("free lock not granted");
   take_busy_a: assert property (
      (holder1 != CMB_HOLD_FREE) && take_rd1[1] && !rel1 |=>
      (host_rsp[1].rdata == 32'h0) && (holder1 == $past(holder1)))
      else $error("taken lock misread");
   release_a: assert property (
      rel1 && (take_rd1 == 4'h0) |=> holder1 == CMB_HOLD_FREE)
      else $error("release ignored");
   resp_ack_a: assert property (
      host_req[2].valid |=> host_rsp[2].ack)
      else $error("request not answered");

   // Soft lines against lock state, force and route.
   irq_route_a: assert property (
      1'b1 |=>
      soft_irq_to_ext_r[0] == ($past(soft_line[0]) & $past(route_r[0])) &&
      soft_irq_to_cpu_r[0] == ($past(soft_line[0]) & ~$past(route_r[0])))
      else $error("soft line routed wrong");
   irq_force_a: assert property (
      force_r[1] |=> soft_irq_to_cpu_r[1] || soft_irq_to_ext_r[1])
      else $error("forced line not asserted");
   irq_state_a: assert property (
      !force_r[0] |->
      soft_line[0] == (pol_r[0] ? holder0 != 3'h0 : holder0 == 3'h0))
      else $error("lock interrupt level wrong");

   // Lock one sets line one from its own state, whatever the route.
   line_one_a: assert property (
      !force_r[1] |=> (soft_irq_to_cpu_r[1] | soft_irq_to_ext_r[1]) ==
      ($past(pol_r[1]) == ($past(holder1) != CMB_HOLD_FREE)))
      else $error("line one not from lock one");

   // A lock moves only through its own requests.
   lock_indep_a: assert property (
      (take_rd1 == 4'h0) && !rel1 |=> holder1 == $past(holder1))
      else $error("lock one moved without a request");

   // Port 0 carries the internal CPU and PCIe, so both get code one.
   cpu_owner_a: assert property (
      (holder0 == CMB_HOLD_FREE) && take_rd0[0] |=> holder0 == 3'h1)
      else $error("shared port holder code wrong");

   // The holder field reads back what the lock unit holds.
   holder_read_a: assert property (
      rd_on[CMB_IDX_HOLD_ZERO][2] |=>
      host_rsp[2].rdata == {29'h0, $past(holder0)})
      else $error("holder field misread");

   // A take write with bit 0 low must leave the holder alone.
   keep_write_a: assert property (
      (wr_on[CMB_IDX_LOCK_ZERO] != 4'h0) && !rel0 && (take_rd0 == 4'h0)
      |=> holder0 == $past(holder0))
      else $error("zero take write moved the lock");

   // Write answers carry no data, and an idle port gets no answer.
   wr_zero_a: assert property (
      host_req[1].valid && host_req[1].wr |=> host_rsp[1].rdata == 32'h0)
      else $error("write answer not zero");
   ack_idle_a: assert property (
      !host_req[0].valid |=> !host_rsp[0].ack)
      else $error("answer without request");

   // A take race on a free lock: every port reads lock one at once.
   sequence race_start_s;
      (holder1 == CMB_HOLD_FREE) && (take_rd1 == 4'hF);
   endsequence

   // Only port 0 sees the one, and it becomes the holder.
   sequence race_result_s;
      (host_rsp[0].rdata == 32'h1) && (host_rsp[1].rdata == 32'h0) &&
      (host_rsp[2].rdata == 32'h0) && (host_rsp[3].rdata == 32'h0) &&
      (holder1 == 3'h1);
   endsequence

   // A release of lock zero with no reader in the same cycle.
   sequence free_zero_s;
      rel0 && (take_rd0 == 4'h0);
   endsequence

   take_race_a: assert property (
      race_start_s |=> race_result_s)
      else $error("same-cycle take not resolved");
   release_zero_a: assert property (
      free_zero_s |=> holder0 == CMB_HOLD_FREE)
      else $error("lock zero release ignored");

endmodule // cmb_mailbox
`default_nettype wire

// file: dv/cmb_host_model.sv
// Behavioural model of the four host CPUs on the core register bus.
`timescale 1ns/100ps
`default_nettype none
module cmb_host_model import cmb_pkg::*; (
   // Clock
   input  wire logic     clock,
   // Requests out, answers back
   output var cmb_req_t  host_req [CMB_PORTS],
   input  wire cmb_rsp_t host_rsp [CMB_PORTS]
);
   // =========================================================
   // Answers seen by each port at the end of the last access, whichever ports it drove
   logic [31:0] rd [CMB_PORTS];
   logic        ak [CMB_PORTS];

   // All ports idle from time zero.
   initial begin
      for (int p = 0; p < 4; p++) begin
         host_req[p] = '0;
      end
   end

   // Drives the masked ports together for one edge, then samples the
   // answer. Released fields show the inverse so nothing stale is read.
   task automatic access(input logic [3:0] m, input logic wr,
                         input logic [3:0] idx, input logic [31:0] wd);
      @(negedge clock);
      for (int p = 0; p < 4; p++) begin
         if (m[p]) host_req[p] = '{1'b1, wr, idx, wd};
      end
      @(negedge clock);
      // The request was taken at the last rising edge and its answer
      // stands until the next one, so read it now, then release.
      for (int p = 0; p < 4; p++) begin
         ak[p] = host_rsp[p].ack;
         rd[p] = host_rsp[p].rdata;
         if (m[p]) host_req[p] = '{1'b0, ~wr, ~idx, ~wd};
      end
   endtask
endmodule // cmb_host_model
`default_nettype wire

// file: dv/cmb_mailbox_tb.sv
// Self-checking testbench of the mailbox and lock block.
`timescale 1ns/100ps
`default_nettype none
module cmb_mailbox_tb import cmb_pkg::*; ();
   cmb_req_t    host_req [CMB_PORTS];
   cmb_rsp_t    host_rsp [CMB_PORTS];
   logic        clock, sys_rst;
   logic [1:0]  irq_cpu, irq_ext, pol, frc, rte, busy;
   logic [31:0] mbox, v;
   integer      seed = 1430;
   int          miscompares = 0, checks = 0, cycles = 0, w;

   // 200 MHz clock.
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   cmb_mailbox uut (.clock(clock), .sys_rst(sys_rst), .host_req(host_req),
      .host_rsp(host_rsp), .soft_irq_to_cpu_r(irq_cpu),
      .soft_irq_to_ext_r(irq_ext));
   cmb_host_model hosts (.clock(clock), .host_req(host_req),
      .host_rsp(host_rsp));

   // =========================================================
   // Checking helpers
   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Every port that asked must see its acknowledge.
   task automatic acc(input logic [3:0] m, input logic wr,
                      input logic [3:0] idx, input logic [31:0] wd);
      hosts.access(m, wr, idx, wd);
      for (int p = 0; p < 4; p++) begin
         if (m[p]) check({31'h0, hosts.ak[p]}, 32'h1);
      end
   endtask

   task automatic rdc(input int p, input logic [3:0] idx,
                      input logic [31:0] exp);
      acc(4'h1 << p, 1'b0, idx, 32'h0);
      check(hosts.rd[p], exp);
   endtask

   // Lowest requesting port wins a shared take.
   function automatic int first_of(input logic [3:0] m);
      int r;
      r = 4;
      for (int i = 3; i >= 0; i--) begin
         if (m[i]) r = i;
      end
      return r;
   endfunction

   // Soft lines from lock state, polarity and force.
   function automatic logic [1:0] lines();
      return (pol & busy) | (~pol & ~busy) | frc;
   endfunction

   // One settling edge, then both outputs against the route.
   task automatic irq_chk();
      @(negedge clock);
      check({30'h0, irq_cpu}, {30'h0, lines() & ~rte});
      check({30'h0, irq_ext}, {30'h0, lines() & rte});
   endtask

   // Hang guard; the full run needs well under this.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         $display("ERROR at %0t: timeout", $time);
         finish_test();
      end
   end

   // =========================================================
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {pol, frc, rte, busy} = 8'h00;
      mbox = 32'h0000_0000;
      repeat (4) @(negedge clock);
      sys_rst = 1'b0;
      irq_chk();
      rdc(0, CMB_IDX_IRQ_CONFIG, 32'h0);
      for (int i = 6; i < 10; i++) rdc(2, 4'(i), 32'h0);
      // Direct, set and clear writes from rotating ports.
      for (int k = 0; k < 40; k++) begin
         v = $random(seed);
         case (k % 3)
            0: mbox = v;
            1: mbox = mbox | v;
            default: mbox = mbox & ~v;
         endcase
         acc(4'h1 << (k % 4), 1'b1, 4'(k % 3), v);
         rdc((k + 1) % 4, CMB_IDX_MBOX_VALUE, mbox);
      end
      rdc(1, CMB_IDX_MBOX_SET, 32'h0);
      rdc(1, CMB_IDX_MBOX_CLEAR, 32'h0);
      // Unmapped words neither store nor disturb the mailbox.
      acc(4'h8, 1'b1, 4'hC, 32'hFFFF_FFFF);
      rdc(3, 4'hC, 32'h0);
      rdc(3, CMB_IDX_MBOX_VALUE, mbox);
      // Reset in mid-run brings the mailbox and lines back to reset.
      @(negedge clock);
      sys_rst = 1'b1;
      repeat (2) @(negedge clock);
      sys_rst = 1'b0;
      mbox = CMB_MBOX_RST;
      irq_chk();
      rdc(0, CMB_IDX_MBOX_VALUE, mbox);
      // Take, refuse, holder, ignored write and foreign release.
      for (int l = 0; l < 2; l++) begin
         for (int p = 0; p < 4; p++) begin
            rdc(p, 4'(4 + l), 32'h1);
            busy[l] = 1'b1;
            rdc(3 - p, 4'(4 + l), 32'h0);
            rdc(p, 4'(4 + l), 32'h0);
            rdc(0, CMB_IDX_HOLD_ZERO + 4'(l), 32'(p + 1));
            rdc(1, CMB_IDX_HOLD_ONE - 4'(l), 32'h0);
            irq_chk();
            acc(4'h1 << ((p + 1) % 4), 1'b1, 4'(4 + l), 32'hFFFF_FFFE);
            rdc(2, CMB_IDX_HOLD_ZERO + 4'(l), 32'(p + 1));
            acc(4'h1 << ((p + 1) % 4), 1'b1, 4'(4 + l), 32'h1);
            busy[l] = 1'b0;
            rdc(2, CMB_IDX_HOLD_ZERO + 4'(l), 32'h0);
         end
      end
      // Same-cycle takes from several ports.
      for (int k = 0; k < 12; k++) begin
         v = $random(seed);
         if (k == 0) v[3:0] = 4'hF;
         if (v[3:0] == 4'h0) v[0] = 1'b1;
         w = first_of(v[3:0]);
         acc(v[3:0], 1'b0, CMB_IDX_LOCK_ONE, 32'h0);
         for (int p = 0; p < 4; p++) begin
            if (v[p]) check(hosts.rd[p], 32'(p == w));
         end
         rdc(3, CMB_IDX_HOLD_ONE, 32'(w + 1));
         acc(4'h2, 1'b1, CMB_IDX_LOCK_ONE, 32'h1);
      end
      // Polarity, force and route against random lock states.
      for (int k = 0; k < 24; k++) begin
         v = $random(seed);
         {rte, frc, pol} = v[5:0];
         acc(4'h1, 1'b1, CMB_IDX_IRQ_CONFIG, {30'h0, pol});
         acc(4'h2, 1'b1, CMB_IDX_IRQ_FORCE, {30'h0, frc});
         acc(4'h4, 1'b1, CMB_IDX_IRQ_ROUTE, {30'h0, rte});
         if (v[6]) begin
            acc(4'h8, busy[0], CMB_IDX_LOCK_ZERO, 32'h1);
            busy[0] = ~busy[0];
         end
         if (v[7]) begin
            acc(4'h4, busy[1], CMB_IDX_LOCK_ONE, 32'h1);
            busy[1] = ~busy[1];
         end
         irq_chk();
         rdc(3, CMB_IDX_IRQ_FORCE, {30'h0, frc});
      end
      finish_test();
   end
endmodule // cmb_mailbox_tb
`default_nettype wire
